/* File: hw/slpd_top.sv */
// Functional notes
// - outputs start on fifth oscillator edge after unblank
// - shared 12-bit counter counts oscillator edges
// - channel off at its value or terminal count
// - period repeats automatically while blank low
// - blank high holds every output off
// - latch strobe rise turns off, restarts period
// - latch strobe rise copies shift register
// - shift register and latch hold 288 bits
// - shift clock rise captures serial_in into lsb
// - serial_out changes only on shift clock fall
// - shift register and latch have no reset
// - on-time equals value over 4096
// - thermal cutoff forces all outputs off
// - after cutoff, resume at next oscillator edge
// - group k is channels with index mod 4 = k
// - groups turn on and off staggered
// - timebase from internal 4 MHz oscillator
//
// top of the 24-channel serial-loaded pwm driver
// assumes ref_clk at 250 MHz; all pins asynchronous to it
`include "slpd_defines.svh"
`default_nettype none

module slpd_top
    import slpd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic shift_clk,
    input wire logic serial_in,
    input wire logic latch_strobe,
    input wire logic blank,
    input wire logic thermal_cutoff,
    output logic serial_out,
    output logic [`SLPD_CHANNELS-1:0] channel_sink
);

    // ====================================================
    // reset release
    logic rst_meta_r;
    logic rst_sync_n;

    // async assert, synchronous release through two flops
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_n <= rst_meta_r;
        end
    end

    // ====================================================
    // pin synchronisers and oscillator
    slpd_pins_t pins_raw;
    slpd_pins_t pins_s;
    logic osc_rise;

    assign pins_raw = '{shift_clk: shift_clk, serial_in: serial_in, latch_strobe: latch_strobe,
                        blank: blank, thermal_cutoff: thermal_cutoff};

    slpd_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_sync_n),
        .pins_in(pins_raw),
        .pins_out(pins_s)
    );

    slpd_osc u_osc (
        .ref_clk(ref_clk),
        .rst_n(rst_sync_n),
        .osc_rise(osc_rise)
    );

    // ====================================================
    // edge detection on the synchronised pins
    logic sclk_d_r;
    logic latch_d_r;
    logic blank_d_r;
    logic sclk_rise;
    logic sclk_fall;
    logic latch_rise;
    logic blank_fall;

    // previous samples; the delayed copy of the data bit is kept in step with sclk
    logic sin_d_r;

    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            sclk_d_r <= 1'b0;
            latch_d_r <= 1'b0;
            blank_d_r <= 1'b1;
            sin_d_r <= 1'b0;
        end
        else
        begin
            sclk_d_r <= pins_s.shift_clk;
            latch_d_r <= pins_s.latch_strobe;
            blank_d_r <= pins_s.blank;
            sin_d_r <= pins_s.serial_in;
        end
    end

    assign sclk_rise = pins_s.shift_clk & ~sclk_d_r;
    assign sclk_fall = ~pins_s.shift_clk & sclk_d_r;
    assign latch_rise = pins_s.latch_strobe & ~latch_d_r;
    assign blank_fall = ~pins_s.blank & blank_d_r;

    // ====================================================
    // shift register and display latch, 288 bits each
    logic [`SLPD_SR_BITS-1:0] shift_r;
    logic [`SLPD_SR_BITS-1:0] latch_r;

    // no reset on the data path: contents undefined until loaded
    always_ff @(posedge ref_clk)
    begin
        if (sclk_rise)
        begin
            // data sampled one ref cycle before the detected edge, as it stood at the rise
            shift_r <= {shift_r[`SLPD_SR_BITS-2:0], sin_d_r};
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (latch_rise)
        begin
            latch_r <= shift_r;
        end
    end

    // serial out moves only on a shift clock fall, so the next device samples a stable bit
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            serial_out <= 1'b0;
        end
        else if (sclk_fall)
        begin
            serial_out <= shift_r[`SLPD_SR_BITS-1];
        end
    end

    // ====================================================
    // pwm sequencer
    slpd_state_t state_r;
    logic [2:0] edge_cnt_r;
    logic [`SLPD_GS_BITS-1:0] gs_cnt_r;
    logic period_start;
    logic run_en;

    // outputs may run only while unblanked and not over temperature
    assign run_en = ~pins_s.blank & ~pins_s.thermal_cutoff;

    // start pulse: period begins on an oscillator edge in the run state
    assign period_start = (state_r == SLPD_ST_RUN) && osc_rise && (gs_cnt_r == `SLPD_GS_MAX);

    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state_r <= SLPD_ST_OFF;
            edge_cnt_r <= 3'h0;
            gs_cnt_r <= `SLPD_GS_MAX;
        end
        else
        begin
            case (state_r)
                SLPD_ST_OFF:
                begin
                    gs_cnt_r <= `SLPD_GS_MAX;
                    edge_cnt_r <= 3'h0;
                    if (run_en && blank_fall)
                    begin
                        state_r <= SLPD_ST_WAIT;
                    end
                    else if (run_en && osc_rise)
                    begin
                        // unblanked after latch or thermal recovery: restart at this edge
                        state_r <= SLPD_ST_RUN;
                        gs_cnt_r <= `SLPD_GS_ZERO;
                    end
                end
                SLPD_ST_WAIT:
                begin
                    if (!run_en)
                    begin
                        state_r <= SLPD_ST_OFF;
                    end
                    else if (osc_rise)
                    begin
                        edge_cnt_r <= edge_cnt_r + 3'h1;
                        if (edge_cnt_r == `SLPD_TURN_ON_EDGE - 3'h1)
                        begin
                            state_r <= SLPD_ST_RUN;
                            gs_cnt_r <= `SLPD_GS_ZERO;
                        end
                    end
                end
                SLPD_ST_RUN:
                begin
                    if (!run_en || latch_rise)
                    begin
                        state_r <= SLPD_ST_OFF;
                    end
                    else if (osc_rise)
                    begin
                        gs_cnt_r <= gs_cnt_r + `SLPD_GS_BITS'(1);
                    end
                end
                default:
                begin
                    state_r <= SLPD_ST_OFF;
                end
            endcase
        end
    end

    // ====================================================
    // per-channel compare and group stagger
    logic [`SLPD_CHANNELS-1:0] want_on;
    logic run_now;

    assign run_now = (state_r == SLPD_ST_RUN) && run_en && !latch_rise;

    genvar ch;
    generate
        for (ch = 0; ch < `SLPD_CHANNELS; ch++)
        begin : g_ch
            logic [`SLPD_GS_BITS-1:0] gs_val;
            logic on_r;
            logic sink_r;
            logic [`SLPD_DLY_W-1:0] dly_r;
            localparam int GRP = ch % `SLPD_GROUPS;
            localparam logic [`SLPD_DLY_W-1:0] DLY = `SLPD_DLY_W'(GRP * `SLPD_GROUP_DELAY_CYC);

            assign gs_val = latch_r[ch*`SLPD_GS_BITS +: `SLPD_GS_BITS];
            // one flop per channel keeps a single driver per output bit
            assign channel_sink[ch] = sink_r;

            // on from count 0 until count equals value: on-time is value/4096
            always_ff @(posedge ref_clk or negedge rst_sync_n)
            begin
                if (!rst_sync_n)
                begin
                    on_r <= 1'b0;
                end
                else if (!run_now)
                begin
                    on_r <= 1'b0;
                end
                else if (period_start || (osc_rise && gs_cnt_r == `SLPD_GS_MAX && state_r != SLPD_ST_RUN))
                begin
                    on_r <= (gs_val != `SLPD_GS_ZERO);
                end
                else if (gs_cnt_r == gs_val || gs_cnt_r == `SLPD_GS_MAX)
                begin
                    on_r <= 1'b0;
                end
                else if (gs_cnt_r == `SLPD_GS_ZERO)
                begin
                    on_r <= (gs_val != `SLPD_GS_ZERO);
                end
            end

            // group delay: each group lags the previous by a fixed step, on both edges
            always_ff @(posedge ref_clk or negedge rst_sync_n)
            begin
                if (!rst_sync_n)
                begin
                    dly_r <= '0;
                    sink_r <= 1'b0;
                end
                else if (!run_en || latch_rise)
                begin
                    // blank, thermal cutoff and latch act at once, no stagger
                    dly_r <= '0;
                    sink_r <= 1'b0;
                end
                else if (on_r == sink_r || dly_r == DLY)
                begin
                    dly_r <= '0;
                    sink_r <= on_r;
                end
                else
                begin
                    dly_r <= dly_r + `SLPD_DLY_W'(1);
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

/* File: include/slpd_defines.svh */
// constants for the serial-loaded 24-channel pwm driver
// assumes inclusion by bare name from the include folder
`ifndef SLPD_DEFINES_SVH
`define SLPD_DEFINES_SVH

`define SLPD_CHANNELS 24
`define SLPD_GS_BITS 12
`define SLPD_SR_BITS 288
`define SLPD_GROUPS 4
`define SLPD_TURN_ON_EDGE 3'h5
`define SLPD_GS_MAX 12'hFFF
`define SLPD_GS_ZERO 12'h000
// ref clock and nominal oscillator rates
`define SLPD_REF_MHZ 250
`define SLPD_OSC_MHZ 4
`define SLPD_OSC_HALF_CYC ((`SLPD_REF_MHZ / `SLPD_OSC_MHZ) / 2)
`define SLPD_OSC_CNT_W 6
// group stagger, nominal 24 ns per group
`define SLPD_GROUP_DELAY_NS 24
`define SLPD_REF_PERIOD_NS 4
`define SLPD_GROUP_DELAY_CYC (`SLPD_GROUP_DELAY_NS / `SLPD_REF_PERIOD_NS)
`define SLPD_DLY_W 5

`endif

/* File: include/slpd_pkg.sv */
// types for the serial-loaded 24-channel pwm driver
// assumes slpd_defines.svh is reachable by bare name
`include "slpd_defines.svh"
`default_nettype none

package slpd_pkg;

    // serial link pins after synchronisation
    typedef struct packed {
        logic shift_clk;
        logic serial_in;
        logic latch_strobe;
        logic blank;
        logic thermal_cutoff;
    } slpd_pins_t;

    // pwm engine states
    typedef enum logic [2:0] {
        SLPD_ST_OFF = 3'b001,
        SLPD_ST_WAIT = 3'b010,
        SLPD_ST_RUN = 3'b100
    } slpd_state_t;

endpackage

`default_nettype wire

/* File: hw/slpd_sync.sv */
// two-flop synchroniser for a bundle of pins
// assumes inputs are asynchronous to ref_clk
`include "slpd_defines.svh"
`default_nettype none

module slpd_sync
    import slpd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire slpd_pins_t pins_in,
    output var slpd_pins_t pins_out
);

    slpd_pins_t meta_r;

    // ====================================================
    // synchroniser pair; first stage feeds only second
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // blank resets to its idle high level so no false fall follows reset
            meta_r <= '{blank: 1'b1, default: 1'b0};
            pins_out <= '{blank: 1'b1, default: 1'b0};
        end
        else
        begin
            meta_r <= pins_in;
            pins_out <= meta_r;
        end
    end

endmodule

`default_nettype wire

/* File: hw/slpd_osc.sv */
// internal grayscale oscillator, divided from ref_clk
// assumes ref_clk runs at the rate in the defines header
`include "slpd_defines.svh"
`default_nettype none

module slpd_osc
    import slpd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    output logic osc_rise
);

    logic [`SLPD_OSC_CNT_W-1:0] div_r;
    logic phase_r;

    // ====================================================
    // free-running divider; a one-cycle pulse marks each rising edge
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_r <= '0;
            phase_r <= 1'b0;
            osc_rise <= 1'b0;
        end
        else if (div_r == `SLPD_OSC_CNT_W'(`SLPD_OSC_HALF_CYC - 1))
        begin
            div_r <= '0;
            phase_r <= ~phase_r;
            osc_rise <= ~phase_r;
        end
        else
        begin
            div_r <= div_r + `SLPD_OSC_CNT_W'(1);
            osc_rise <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* File: bench/slpd_checker.sv */
// concurrent checks on the pins of the pwm driver top
// assumes pins move at least 4 ref cycles apart, as the driver needs
`include "slpd_defines.svh"
`default_nettype none

module slpd_checker
    import slpd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic shift_clk,
    input wire logic serial_in,
    input wire logic latch_strobe,
    input wire logic blank,
    input wire logic thermal_cutoff,
    input wire logic serial_out,
    input wire logic [`SLPD_CHANNELS-1:0] channel_sink
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ==========================================
    // helper: channels that turned on this cycle
    logic [`SLPD_CHANNELS-1:0] prev_r;
    logic [`SLPD_CHANNELS-1:0] rise;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            prev_r <= '0;
        else
            prev_r <= channel_sink;
    end
    assign rise = channel_sink & ~prev_r;

    // ==========================================
    // assertions; margins cover the pin synchronisers
    AST_BLANK_OFF: assert property (blank [*5] |-> channel_sink == '0)
        else $error("outputs on while blanked");
    AST_ON_BLANK: assert property (|rise |-> !($past(blank, 4) && $past(blank, 5)))
        else $error("channel turned on while blanked");
    AST_THERM_OFF: assert property ($rose(thermal_cutoff) |-> ##[1:5] channel_sink == '0)
        else $error("outputs not cut on overheat");
    AST_ON_THERM: assert property (|rise |-> !($past(thermal_cutoff, 4) && $past(thermal_cutoff, 5)))
        else $error("channel turned on during overheat");
    AST_LATCH_OFF: assert property ($rose(latch_strobe) |-> ##[1:5] channel_sink == '0)
        else $error("outputs not off after latch");
    AST_SERIAL_OUT_EDGE: assert property ($changed(serial_out) |-> $past(shift_clk, 6) && !$past(shift_clk, 3))
        else $error("serial out moved off a falling edge");
    AST_SERIAL_OUT_HOLD: assert property (shift_clk [*8] |-> $stable(serial_out))
        else $error("serial out moved while shift clock high");
    AST_SERIAL_OUT_IDLE: assert property (!shift_clk [*8] |-> $stable(serial_out))
        else $error("serial out moved while shift clock low");
    AST_GROUP_APART: assert property (|(rise & 24'h111111) |-> !(|(rise & 24'h888888)))
        else $error("first and last group turned on together");

    cover property (|rise);
    cover property ($changed(serial_out));
    cover property ($rose(thermal_cutoff) ##5 channel_sink == '0);
endmodule

bind slpd_top slpd_checker CHK (.ref_clk(ref_clk), .rst_n(rst_n), .shift_clk(shift_clk),
    .serial_in(serial_in), .latch_strobe(latch_strobe), .blank(blank),
    .thermal_cutoff(thermal_cutoff), .serial_out(serial_out), .channel_sink(channel_sink));

`default_nettype wire

/* File: bench/slpd_host_model.sv */
// host model: shifts frames msb first, pulses the latch strobe
// assumes the bench calls send between ref clock edges; shift clock 80 ns, idle low
`include "slpd_defines.svh"
`default_nettype none

module slpd_host_model
    import slpd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic serial_out,
    output logic shift_clk,
    output logic serial_in,
    output logic latch_strobe,
    output logic [31:0] echo
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================
    // idle levels; shift clock stands still between frames
    initial
    begin
        shift_clk = 1'b0;
        serial_in = 1'b0;
        latch_strobe = 1'b0;
        echo = '0;
    end

    // ==========================================
    // n bits from d, top bit first; echo samples serial_out like a chained part
    task automatic send(input logic [287:0] d, input int n, input logic lat);
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_in <= d[i];
            repeat (5) @(posedge ref_clk);
            shift_clk <= 1'b1;
            echo <= {echo[30:0], serial_out};
            repeat (10) @(posedge ref_clk);
            shift_clk <= 1'b0;
            repeat (5) @(posedge ref_clk);
        end
        // released data line shows the inverse, never the stale bit
        serial_in <= ~serial_in;
        if (lat)
        begin
            repeat (5) @(posedge ref_clk);
            latch_strobe <= 1'b1;
            repeat (10) @(posedge ref_clk);
            latch_strobe <= 1'b0;
        end
        @(posedge ref_clk);
    endtask
endmodule

`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench for the pwm driver top
// assumes the checker binds itself; full pwm period too long, on-times checked only for short values
`include "slpd_defines.svh"
`default_nettype none

module tb
    import slpd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst_n, blank, thermal_cutoff, shift_clk, serial_in, latch_strobe, serial_out, lat_prev;
    logic [`SLPD_CHANNELS-1:0] channel_sink, sink_prev;
    logic [31:0] echo, t0, lat_t;
    logic [31:0] cyc = '0;
    logic [31:0] rise_t [24];
    logic [31:0] fall_t [24];
    int mismatches = 0;
    int n_checks = 0;

    slpd_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .shift_clk(shift_clk), .serial_in(serial_in),
        .latch_strobe(latch_strobe), .blank(blank), .thermal_cutoff(thermal_cutoff),
        .serial_out(serial_out), .channel_sink(channel_sink));
    slpd_host_model HOST (.ref_clk(ref_clk), .serial_out(serial_out), .shift_clk(shift_clk),
        .serial_in(serial_in), .latch_strobe(latch_strobe), .echo(echo));

    // ==========================================
    // clock, and edge times of every channel; ceiling cuts a hang
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 32'h1;
        sink_prev <= channel_sink;
        lat_prev <= latch_strobe;
        if (latch_strobe === 1'b1 && lat_prev === 1'b0)
            lat_t <= cyc;
        for (int i = 0; i < 24; i++)
        begin
            if (channel_sink[i] === 1'b1 && sink_prev[i] === 1'b0)
                rise_t[i] <= cyc;
            if (channel_sink[i] === 1'b0 && sink_prev[i] === 1'b1)
                fall_t[i] <= cyc;
        end
        if (cyc == 32'h7530)
        begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // ch0-3 = a, ch5 = b, ch23 = A53, rest zero
    function automatic logic [287:0] frame(input logic [11:0] a, input logic [11:0] b);
        logic [287:0] f;
        f = '0;
        for (int n = 0; n < 4; n++)
            f[12*n +: 12] = a;
        f[60 +: 12] = b;
        f[276 +: 12] = 12'hA53;
        return f;
    endfunction

    // ==========================================
    // scenarios
    task automatic t_chain();
        HOST.send(frame(12'h003, 12'h001), 288, 1'b1);
        HOST.send('0, 12, 1'b0);
        chk("chained echo", 32'hA53, {20'h0, echo[11:0]});
    endtask

    task automatic t_pwm();
        blank <= 1'b0;
        t0 = cyc;
        repeat (600) @(posedge ref_clk);
        chk("turn on delay", 1, (rise_t[0] - t0 >= 250) && (rise_t[0] - t0 <= 320));
        for (int k = 1; k < 4; k++)
            chk("group lag", 6 * k, rise_t[k] - rise_t[0]);
        chk("on time ch0", 186, fall_t[0] - rise_t[0]);
        chk("on time ch3", 186, fall_t[3] - rise_t[3]);
        chk("on time ch5", 62, fall_t[5] - rise_t[5]);
        chk("zero channel", 0, rise_t[4]);
        chk("long channel on", 1, channel_sink[23]);
    endtask

    task automatic t_thermal();
        thermal_cutoff <= 1'b1;
        repeat (100) @(posedge ref_clk);
        chk("cut off", 0, channel_sink);
        thermal_cutoff <= 1'b0;
        t0 = cyc;
        repeat (300) @(posedge ref_clk);
        chk("resume delay", 1, (rise_t[0] - t0 >= 3) && (rise_t[0] - t0 <= 72));
        chk("resume on time", 186, fall_t[0] - rise_t[0]);
    endtask

    task automatic t_latch();
        HOST.send(frame(12'h001, 12'h005), 288, 1'b1);
        repeat (400) @(posedge ref_clk);
        chk("restart delay", 1, (rise_t[0] - lat_t >= 3) && (rise_t[0] - lat_t <= 75));
        chk("new on time ch0", 62, fall_t[0] - rise_t[0]);
        chk("new on time ch5", 310, fall_t[5] - rise_t[5]);
    endtask

    task automatic t_blank();
        blank <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk("blanked", 0, channel_sink);
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================
    // main sequence; blank held until data is latched
    initial
    begin
        rst_n = 1'b0;
        blank = 1'b1;
        thermal_cutoff = 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            rise_t[i] = '0;
            fall_t[i] = '0;
        end
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        t_chain();
        t_pwm();
        t_thermal();
        t_latch();
        t_blank();
        wrap_up();
    end
endmodule

`default_nettype wire
